/* File: rtl/acdr_regs.svh */
// Encodings, field positions and FIFO size for the audio clock and data router
`ifndef ACDR_REGS_SVH
`define ACDR_REGS_SVH

// Domain-one master clock source codes
`define ACDR_M1_OSC        2'h0
`define ACDR_M1_HDR        2'h1
`define ACDR_M1_COPY       2'h2

// Domain-two master clock source codes
`define ACDR_M2_OSC        2'h0
`define ACDR_M2_RECOV      2'h1
`define ACDR_M2_HDR        2'h2
`define ACDR_M2_COPY       2'h3

// Sub-clock pair source codes (per domain)
`define ACDR_SUB_CODEC     2'h0
`define ACDR_SUB_SPDIF     2'h1
`define ACDR_SUB_HDR       2'h2
`define ACDR_SUB_COPY      2'h3

// Serial data source codes
`define ACDR_SD_RECV       2'h0
`define ACDR_SD_HDR        2'h1
`define ACDR_SD_CODEC      2'h2

// Reset values of the settings
`define ACDR_RST_SEL       2'h0
`define ACDR_RST_DIR       1'h0

// Field positions in the packed setting word
`define ACDR_F_M1          0
`define ACDR_F_S1          2
`define ACDR_F_M2          4
`define ACDR_F_S2          6
`define ACDR_F_SD1         8
`define ACDR_F_SD2         10
`define ACDR_F_DIR1        12
`define ACDR_F_DIR2        13
`define ACDR_CFG_W         14

// Depth and width of the setting FIFO
`define ACDR_FIFO_DEPTH    8
`define ACDR_FIFO_W        14

`endif

/* File: rtl/acdr_pkg.sv */
// Types for the audio clock and data router
`default_nettype none
package acdr_pkg;

    typedef logic [1:0] acdr_sel_t;

    typedef struct packed
    {
        logic      dir2;
        logic      dir1;
        acdr_sel_t sd2;
        acdr_sel_t sd1;
        acdr_sel_t s2;
        acdr_sel_t m2;
        acdr_sel_t s1;
        acdr_sel_t m1;
    } acdr_cfg_s;

    typedef enum logic [2:0]
    {
        ACDR_ST_IDLE = 3'b001,
        ACDR_ST_REQ  = 3'b010,
        ACDR_ST_ACK  = 3'b100
    } acdr_xfer_e;

endpackage
`default_nettype wire

/* File: rtl/acdr_fifo_if.sv */
// Handshake bundle between the router core and its setting FIFO
`timescale 1ns/1ns
`default_nettype none
interface acdr_fifo_if;
    logic        in_valid;
    logic        in_ready;
    logic [13:0] in_data;
    logic        out_valid;
    logic        out_ready;
    logic [13:0] out_data;

    modport core (output in_valid, input in_ready, output in_data,
                  input out_valid, output out_ready, input out_data);
    modport fifo (input in_valid, output in_ready, input in_data,
                  output out_valid, input out_ready, output out_data);
endinterface
`default_nettype wire

/* File: rtl/acdr_fifo.sv */
// Synchronous FIFO of flip-flops with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none
`include "acdr_regs.svh"
module acdr_fifo
#(
    parameter int WIDTH = `ACDR_FIFO_W,
    parameter int DEPTH = `ACDR_FIFO_DEPTH
)
(
    input  wire logic i_clk,
    input  wire logic i_nrst,
    acdr_fifo_if.fifo f
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed
    {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wr;
        logic [AW-1:0]               rd;
        logic [AW:0]                 cnt;
    } acdr_fifo_s;

    acdr_fifo_s st_q;
    acdr_fifo_s st_d;
    logic       push;
    logic       pop;

    assign f.in_ready  = (st_q.cnt != (AW+1)'(DEPTH));
    assign f.out_valid = (st_q.cnt != '0);
    assign f.out_data  = st_q.mem[st_q.rd];
    assign push        = f.in_valid && f.in_ready;
    assign pop         = f.out_valid && f.out_ready;

    always_comb
    begin
        st_d = st_q;
        if (push)
        begin
            st_d.mem[st_q.wr] = f.in_data;
            st_d.wr = st_q.wr + 1'b1;
        end
        if (pop)
            st_d.rd = st_q.rd + 1'b1;
        if (push && !pop)
            st_d.cnt = st_q.cnt + 1'b1;
        else if (pop && !push)
            st_d.cnt = st_q.cnt - 1'b1;
    end

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            st_q <= '0;
        else
            st_q <= st_d;
    end
endmodule
`default_nettype wire

/* File: rtl/acdr_router.sv */
// Audio clock and data router: host settings, clock and data muxes
`timescale 1ns/1ns
`default_nettype none
`include "acdr_regs.svh"
module acdr_router
(
    input  wire logic        i_clk,
    input  wire logic        i_nrst,
    // Host setting port, host clock domain
    input  wire logic        i_cfg_wr,
    input  wire logic [13:0] i_cfg_data,
    input  wire logic        i_cfg_defaults,
    output logic             o_cfg_ready,
    output logic [13:0]      o_cfg_active,
    output logic             o_cfg_busy,
    // Link clock: domain-one master clock as routed
    input  wire logic        i_link_clk,
    // Sources
    input  wire logic        i_first_oscillator,
    input  wire logic        i_second_oscillator,
    input  wire logic        i_recovered_master_clock_out,
    input  wire logic        i_codec_bit_clock_1,
    input  wire logic        i_codec_frame_clock_1,
    input  wire logic        i_codec_bit_clock_2,
    input  wire logic        i_codec_frame_clock_2,
    input  wire logic        i_tx_bit_clock,
    input  wire logic        i_tx_frame_clock,
    input  wire logic        i_rx_bit_clock,
    input  wire logic        i_rx_frame_clock,
    input  wire logic        i_rx_serial_audio_output,
    input  wire logic        i_codec_serial_audio_output,
    // Port-one header pins: master, bit, frame clock
    input  wire logic [2:0]  i_hdr1,
    output logic      [2:0]  o_hdr1,
    output logic      [2:0]  o_hdr1_oe,
    // Port-two header pins: master, bit, frame clock, data
    input  wire logic [3:0]  i_hdr2,
    output logic      [3:0]  o_hdr2,
    output logic      [3:0]  o_hdr2_oe,
    // Routed outputs
    output logic             o_domain_one_master_clock,
    output logic             o_domain_one_bit_clock,
    output logic             o_domain_one_frame_clock,
    output logic             o_domain_two_master_clock,
    output logic             o_domain_two_bit_clock,
    output logic             o_domain_two_frame_clock,
    output logic             o_codec_serial_audio_input,
    output logic             o_tx_serial_audio_input
);
    // ------------------------------------------------------------
    // Host side: settings queue and handshake toward link domain
    // ------------------------------------------------------------
    typedef struct packed
    {
        acdr_pkg::acdr_xfer_e state;
        logic [13:0]          word;
        logic                 req;
        logic [1:0]           ack_sync;
        logic [1:0]           dflt_sync;
        logic [13:0]          active;
    } acdr_host_s;

    acdr_host_s  h_q;
    acdr_host_s  h_d;
    acdr_fifo_if fq ();
    logic [13:0] rst_word;

    // Defaults: every selector code zero, both headers receiving
    assign rst_word = {`ACDR_RST_DIR, `ACDR_RST_DIR,
                       `ACDR_RST_SEL, `ACDR_RST_SEL, `ACDR_RST_SEL,
                       `ACDR_RST_SEL, `ACDR_RST_SEL, `ACDR_RST_SEL};

    // A defaults request travels through the same queue as a write
    assign fq.in_valid = i_cfg_wr || i_cfg_defaults;
    assign fq.in_data  = i_cfg_defaults ? rst_word : i_cfg_data;
    assign o_cfg_ready = fq.in_ready;

    acdr_fifo #(.WIDTH(`ACDR_FIFO_W), .DEPTH(`ACDR_FIFO_DEPTH)) u_fifo
    (
        .i_clk  (i_clk),
        .i_nrst (i_nrst),
        .f      (fq.fifo)
    );

    logic ack_l;

    // Queue drains only while no word is in flight, so it can fill
    assign fq.out_ready = (h_q.state == acdr_pkg::ACDR_ST_IDLE);

    always_comb
    begin
        h_d = h_q;
        h_d.ack_sync = {h_q.ack_sync[0], ack_l};
        unique case (h_q.state)
            acdr_pkg::ACDR_ST_IDLE:
            begin
                if (fq.out_valid)
                begin
                    h_d.word  = fq.out_data;
                    h_d.req   = 1'b1;
                    h_d.state = acdr_pkg::ACDR_ST_REQ;
                end
            end
            acdr_pkg::ACDR_ST_REQ:
            begin
                if (h_q.ack_sync[1])
                begin
                    h_d.req    = 1'b0;
                    h_d.active = h_q.word;
                    h_d.state  = acdr_pkg::ACDR_ST_ACK;
                end
            end
            acdr_pkg::ACDR_ST_ACK:
            begin
                // Four-phase: a new req is only seen once ack has dropped
                if (!h_q.ack_sync[1])
                    h_d.state = acdr_pkg::ACDR_ST_IDLE;
            end
            default:
                h_d.state = acdr_pkg::ACDR_ST_IDLE;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            h_q       <= '0;
            h_q.state <= acdr_pkg::ACDR_ST_IDLE;
        end
        else
            h_q <= h_d;
    end

    assign o_cfg_active = h_q.active;
    assign o_cfg_busy   = fq.out_valid ||
                          (h_q.state != acdr_pkg::ACDR_ST_IDLE);

    // ------------------------------------------------------------
    // Link side: settings captured on the link clock
    // ------------------------------------------------------------
    typedef struct packed
    {
        logic [1:0]          req_sync;
        logic                ack;
        acdr_pkg::acdr_cfg_s cfg;
    } acdr_link_s;

    acdr_link_s l_q;
    acdr_link_s l_d;
    logic [1:0] lrst_q;
    logic       link_nrst;

    // Link-domain reset asserts at once but releases two link edges
    // late, so the capture logic never leaves reset on a marginal edge
    always_ff @(posedge i_link_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            lrst_q <= 2'h0;
        else
            lrst_q <= {lrst_q[0], 1'b1};
    end

    assign link_nrst = lrst_q[1];

    // Word is stable while req is high, so no bit of it can tear
    always_comb
    begin
        l_d = l_q;
        l_d.req_sync = {l_q.req_sync[0], h_q.req};
        if (l_q.req_sync[1] && !l_q.ack)
            l_d.cfg = acdr_pkg::acdr_cfg_s'(h_q.word);
        l_d.ack = l_q.req_sync[1];
    end

    always_ff @(posedge i_link_clk or negedge link_nrst)
    begin
        if (!link_nrst)
            l_q <= '0;
        else
            l_q <= l_d;
    end

    assign ack_l = l_q.ack;

    // ------------------------------------------------------------
    // Clock and data muxes
    // ------------------------------------------------------------
    // Combinational paths: these carry audio clocks, so a register
    // would only divide or skew them. A setting change may glitch.
    acdr_pkg::acdr_cfg_s c;
    assign c = l_q.cfg;

    always_comb
    begin
        // Domain one: oscillator one, header one, copy of domain two
        unique case (c.m1)
            `ACDR_M1_HDR:  o_domain_one_master_clock = i_hdr1[0];
            `ACDR_M1_COPY: o_domain_one_master_clock = i_recovered_m2();
            default:       o_domain_one_master_clock = i_first_oscillator;
        endcase
    end

    function automatic logic i_recovered_m2();
        logic r;
        r = i_second_oscillator;
        unique case (c.m2)
            `ACDR_M2_RECOV: r = i_recovered_master_clock_out;
            `ACDR_M2_HDR:   r = i_hdr2[0];
            `ACDR_M2_COPY:  r = i_first_oscillator;
            default:        r = i_second_oscillator;
        endcase
        return r;
    endfunction

    always_comb
    begin
        // Domain two: oscillator two, receiver, header two
        unique case (c.m2)
            `ACDR_M2_COPY:
            begin
                // Copy of domain one, breaking the loop at the base
                unique case (c.m1)
                    `ACDR_M1_HDR: o_domain_two_master_clock = i_hdr1[0];
                    default:
                        o_domain_two_master_clock = i_first_oscillator;
                endcase
            end
            default: o_domain_two_master_clock = i_recovered_m2();
        endcase
    end

    logic [1:0] sub1_base;
    logic [1:0] sub2_base;

    // Header pins carry frame above bit; the pair is {bit, frame}
    always_comb
    begin
        unique case (c.s1)
            `ACDR_SUB_SPDIF: sub1_base = {i_tx_bit_clock, i_tx_frame_clock};
            `ACDR_SUB_HDR:   sub1_base = {i_hdr1[1], i_hdr1[2]};
            default:
                sub1_base = {i_codec_bit_clock_1, i_codec_frame_clock_1};
        endcase
        unique case (c.s2)
            `ACDR_SUB_SPDIF: sub2_base = {i_rx_bit_clock, i_rx_frame_clock};
            `ACDR_SUB_HDR:   sub2_base = {i_hdr2[1], i_hdr2[2]};
            default:
                sub2_base = {i_codec_bit_clock_2, i_codec_frame_clock_2};
        endcase
        // Copy both ways at once would loop; domain two base then wins
        {o_domain_one_bit_clock, o_domain_one_frame_clock} =
            (c.s1 == `ACDR_SUB_COPY) ? sub2_base : sub1_base;
        {o_domain_two_bit_clock, o_domain_two_frame_clock} =
            (c.s2 == `ACDR_SUB_COPY && c.s1 != `ACDR_SUB_COPY) ?
            sub1_base : sub2_base;
    end

    always_comb
    begin
        unique case (c.sd1)
            `ACDR_SD_HDR:   o_codec_serial_audio_input = i_hdr2[3];
            `ACDR_SD_CODEC: o_codec_serial_audio_input =
                            i_codec_serial_audio_output;
            default:        o_codec_serial_audio_input =
                            i_rx_serial_audio_output;
        endcase
        unique case (c.sd2)
            `ACDR_SD_HDR:   o_tx_serial_audio_input = i_hdr2[3];
            `ACDR_SD_CODEC: o_tx_serial_audio_input =
                            i_codec_serial_audio_output;
            default:        o_tx_serial_audio_input =
                            i_rx_serial_audio_output;
        endcase
    end

    // ------------------------------------------------------------
    // Header drivers
    // ------------------------------------------------------------
    assign o_hdr1    = {o_domain_one_frame_clock, o_domain_one_bit_clock,
                        o_domain_one_master_clock};
    assign o_hdr1_oe = {3{c.dir1}};
    assign o_hdr2    = {i_codec_serial_audio_output,
                        o_domain_two_frame_clock, o_domain_two_bit_clock,
                        o_domain_two_master_clock};
    assign o_hdr2_oe = {4{c.dir2}};
endmodule
`default_nettype wire

/* File: verification/acdr_far_side.sv */
// Far-side model: source chips, oscillators and header pins
`timescale 1ns/1ns
`default_nettype none
module acdr_far_side
(
    input  wire logic [19:0] i_src,
    input  wire logic [6:0]  i_drv,
    input  wire logic [6:0]  i_oe,
    output logic      [19:0] o_lvl
);
    // Recovered clock is held as a level stand-in for 128 or 256 Fs
    assign o_lvl[12:0] = i_src[12:0];
    // The router wins the wire only where it enables; else we drive
    for (genvar k = 0; k < 7; k++)
    begin : g_pin
        assign o_lvl[13+k] = i_oe[k] ? i_drv[k] : i_src[13+k];
    end
endmodule
`default_nettype wire

/* File: verification/acdr_router_properties.sv */
// Checker on the router's top-level ports
`timescale 1ns/1ns
`default_nettype none
module acdr_router_properties
(
    input wire logic        i_clk,
    input wire logic        i_nrst,
    input wire logic        o_cfg_ready,
    input wire logic        o_cfg_busy,
    input wire logic [13:0] o_cfg_active,
    input wire logic        i_first_oscillator,
    input wire logic        i_recovered_master_clock_out,
    input wire logic        i_codec_bit_clock_1,
    input wire logic        i_rx_serial_audio_output,
    input wire logic        i_codec_serial_audio_output,
    input wire logic [2:0]  o_hdr1,
    input wire logic [2:0]  o_hdr1_oe,
    input wire logic [3:0]  o_hdr2,
    input wire logic [3:0]  o_hdr2_oe,
    input wire logic        o_domain_one_master_clock,
    input wire logic        o_domain_one_bit_clock,
    input wire logic        o_domain_one_frame_clock,
    input wire logic        o_domain_two_master_clock,
    input wire logic        o_domain_two_bit_clock,
    input wire logic        o_domain_two_frame_clock,
    input wire logic        o_codec_serial_audio_input,
    input wire logic        o_tx_serial_audio_input
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    // Mux routes are only judged once no setting is in flight; header pins are judged whenever driven
    property p_m1_osc;
        o_cfg_active[1:0] == 2'h0 && !o_cfg_busy
        |-> o_domain_one_master_clock == i_first_oscillator;
    endproperty
    a_m1_osc: assert property (p_m1_osc) else $error("m1 not osc");
    property p_s1_codec;
        o_cfg_active[3:2] == 2'h0 && !o_cfg_busy
        |-> o_domain_one_bit_clock == i_codec_bit_clock_1;
    endproperty
    a_s1_codec: assert property (p_s1_codec) else $error("s1 bad");
    property p_m2_rec;
        o_cfg_active[5:4] == 2'h1 && !o_cfg_busy
        |-> o_domain_two_master_clock == i_recovered_master_clock_out;
    endproperty
    a_m2_rec: assert property (p_m2_rec) else $error("m2 bad");
    property p_s2_copy;
        o_cfg_active[7:6] == 2'h3 && o_cfg_active[3:2] == 2'h0
        && !o_cfg_busy |-> o_domain_two_bit_clock == i_codec_bit_clock_1;
    endproperty
    a_s2_copy: assert property (p_s2_copy) else $error("s2 bad");
    property p_sd_loop;
        o_cfg_active[9:8] == 2'h2 && !o_cfg_busy
        |-> o_codec_serial_audio_input == i_codec_serial_audio_output;
    endproperty
    a_sd_loop: assert property (p_sd_loop) else $error("sd bad");
    property p_tx_rx;
        o_cfg_active[11:10] == 2'h0 && !o_cfg_busy
        |-> o_tx_serial_audio_input == i_rx_serial_audio_output;
    endproperty
    a_tx_rx: assert property (p_tx_rx) else $error("tx data bad");
    property p_dir;
        !o_cfg_busy |-> o_hdr1_oe == {3{o_cfg_active[12]}}
        && o_hdr2_oe == {4{o_cfg_active[13]}};
    endproperty
    a_dir: assert property (p_dir) else $error("oe bad");
    property p_hdr1;
        o_hdr1_oe == 3'h7 |-> o_hdr1 == {o_domain_one_frame_clock,
        o_domain_one_bit_clock, o_domain_one_master_clock};
    endproperty
    a_hdr1: assert property (p_hdr1) else $error("hdr1 bad");
    property p_hdr2;
        o_hdr2_oe == 4'hf |-> o_hdr2 == {i_codec_serial_audio_output,
        o_domain_two_frame_clock, o_domain_two_bit_clock,
        o_domain_two_master_clock};
    endproperty
    a_hdr2: assert property (p_hdr2) else $error("hdr2 bad");
    property p_chg;
        !$stable(o_cfg_active) |-> $past(o_cfg_busy);
    endproperty
    a_chg: assert property (p_chg) else $error("active moved idle");
    property p_full;
        !o_cfg_ready |-> o_cfg_busy;
    endproperty
    a_full: assert property (p_full) else $error("full not busy");
endmodule
bind acdr_router acdr_router_properties u_props (.i_clk(i_clk),
    .i_nrst(i_nrst), .o_cfg_ready(o_cfg_ready), .o_cfg_busy(o_cfg_busy),
    .o_cfg_active(o_cfg_active), .i_first_oscillator(i_first_oscillator),
    .i_recovered_master_clock_out(i_recovered_master_clock_out),
    .i_codec_bit_clock_1(i_codec_bit_clock_1),
    .i_rx_serial_audio_output(i_rx_serial_audio_output),
    .i_codec_serial_audio_output(i_codec_serial_audio_output),
    .o_hdr1(o_hdr1), .o_hdr1_oe(o_hdr1_oe), .o_hdr2(o_hdr2),
    .o_hdr2_oe(o_hdr2_oe),
    .o_domain_one_master_clock(o_domain_one_master_clock),
    .o_domain_one_bit_clock(o_domain_one_bit_clock),
    .o_domain_one_frame_clock(o_domain_one_frame_clock),
    .o_domain_two_master_clock(o_domain_two_master_clock),
    .o_domain_two_bit_clock(o_domain_two_bit_clock),
    .o_domain_two_frame_clock(o_domain_two_frame_clock),
    .o_codec_serial_audio_input(o_codec_serial_audio_input),
    .o_tx_serial_audio_input(o_tx_serial_audio_input));
`default_nettype wire

/* File: verification/acdr_router_tb.sv */
// Self-checking bench for the audio clock and data router
`timescale 1ns/1ns
`default_nettype none
module acdr_router_tb;
    logic        clk, nrst, wr, dflt, link_clk, link_run;
    logic [13:0] wdata, act;
    logic [19:0] src;
    logic        rdy, busy;
    logic [2:0]  h1, h1oe;
    logic [3:0]  h2, h2oe;
    wire logic [7:0]  obs;
    wire logic [19:0] lvl;
    int          n_errors, check_count, cycles, k, acc, last;

    acdr_far_side u_far (.i_src(src), .i_drv({h2, h1}),
        .i_oe({h2oe, h1oe}), .o_lvl(lvl));
    acdr_router u_dut (.i_clk(clk), .i_nrst(nrst), .i_cfg_wr(wr),
        .i_cfg_data(wdata), .i_cfg_defaults(dflt), .o_cfg_ready(rdy),
        .o_cfg_active(act), .o_cfg_busy(busy), .i_link_clk(link_clk),
        .i_first_oscillator(lvl[0]), .i_second_oscillator(lvl[1]),
        .i_recovered_master_clock_out(lvl[2]),
        .i_codec_bit_clock_1(lvl[3]), .i_codec_frame_clock_1(lvl[4]),
        .i_codec_bit_clock_2(lvl[5]), .i_codec_frame_clock_2(lvl[6]),
        .i_tx_bit_clock(lvl[7]), .i_tx_frame_clock(lvl[8]),
        .i_rx_bit_clock(lvl[9]), .i_rx_frame_clock(lvl[10]),
        .i_rx_serial_audio_output(lvl[11]),
        .i_codec_serial_audio_output(lvl[12]),
        .i_hdr1(lvl[15:13]), .o_hdr1(h1), .o_hdr1_oe(h1oe),
        .i_hdr2(lvl[19:16]), .o_hdr2(h2), .o_hdr2_oe(h2oe),
        .o_domain_one_master_clock(obs[0]),
        .o_domain_one_bit_clock(obs[1]), .o_domain_one_frame_clock(obs[2]),
        .o_domain_two_master_clock(obs[3]),
        .o_domain_two_bit_clock(obs[4]), .o_domain_two_frame_clock(obs[5]),
        .o_codec_serial_audio_input(obs[6]),
        .o_tx_serial_audio_input(obs[7]));

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Gated so the queue can be filled while the link stands still
    initial
    begin
        link_clk = 1'b0;
        #3;
        forever #6 link_clk = link_run & ~link_clk;
    end

    task end_of_test;
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            n_errors++;
            end_of_test;
        end
    end

    task tick;
        @(posedge clk);
        #1;
    endtask

    task cmp(input string n, input logic [13:0] e, input logic [13:0] g);
        check_count++;
        if (g !== e)
        begin
            $display("mismatch %s expected %h seen %h", n, e, g);
            n_errors++;
        end
    endtask

    // Bounded wait for the setting to cross and be acknowledged
    task settle;
        for (int i = 0; i < 400 && busy !== 1'b0; i++)
            tick;
        cmp("busy", 14'h0, {13'h0, busy});
        tick;
    endtask

    task apply(input logic [13:0] w);
        wr = 1'b1;
        wdata = w;
        tick;
        wr = 1'b0;
        settle;
        cmp("active", w, act);
    endtask

    // Route one source (p=1: bit and frame pair) and watch it toggle
    task chk(input int m1, s1, m2, s2, c, t, s, d, p);
        logic [13:0] w;
        w = {2'h0, t[1:0], c[1:0], s2[1:0], m2[1:0], s1[1:0], m1[1:0]};
        apply(w);
        for (int j = 0; j <= p; j++)
        begin
            src = 20'h1 << (s + j);
            tick;
            cmp("route high", 14'h1, {13'h0, obs[d+j]});
            src = ~(20'h1 << (s + j));
            tick;
            cmp("route low", 14'h0, {13'h0, obs[d+j]});
        end
    endtask

    initial
    begin
        nrst = 1'b0;
        wr = 1'b0;
        dflt = 1'b0;
        wdata = 14'h0;
        src = 20'h0;
        link_run = 1'b1;
        repeat (6) @(posedge clk);
        #1;
        nrst = 1'b1;
        tick;
        cmp("active", 14'h0, act);
        chk(0, 0, 0, 0, 0, 0, 0, 0, 0);
        chk(1, 0, 0, 0, 0, 0, 13, 0, 0);
        chk(2, 0, 0, 0, 0, 0, 1, 0, 0);
        chk(0, 0, 0, 0, 0, 0, 3, 1, 1);
        chk(0, 1, 0, 0, 0, 0, 7, 1, 1);
        chk(0, 2, 0, 0, 0, 0, 14, 1, 1);
        chk(0, 3, 0, 0, 0, 0, 5, 1, 1);
        chk(0, 0, 0, 0, 0, 0, 1, 3, 0);
        chk(0, 0, 1, 0, 0, 0, 2, 3, 0);
        chk(0, 0, 2, 0, 0, 0, 16, 3, 0);
        chk(0, 0, 3, 0, 0, 0, 0, 3, 0);
        chk(0, 0, 0, 0, 0, 0, 5, 4, 1);
        chk(0, 0, 0, 1, 0, 0, 9, 4, 1);
        chk(0, 0, 0, 2, 0, 0, 17, 4, 1);
        chk(0, 0, 0, 3, 0, 0, 3, 4, 1);
        chk(0, 0, 0, 0, 0, 0, 11, 6, 0);
        chk(0, 0, 0, 0, 1, 0, 19, 6, 0);
        chk(0, 0, 0, 0, 2, 0, 12, 6, 0);
        chk(0, 0, 0, 0, 0, 0, 11, 7, 0);
        chk(0, 0, 0, 0, 0, 1, 19, 7, 0);
        chk(0, 0, 0, 0, 0, 2, 12, 7, 0);
        $display("test routing done");
        src = 20'h8;
        apply(14'h3000);
        cmp("oe1", 14'h7, {11'h0, h1oe});
        cmp("oe2", 14'hf, {10'h0, h2oe});
        cmp("hdr1", 14'h2, {11'h0, h1});
        src = 20'h1000;
        tick;
        cmp("hdr2", 14'h8, {10'h0, h2});
        dflt = 1'b1;
        tick;
        dflt = 1'b0;
        settle;
        cmp("active", 14'h0, act);
        cmp("oe1", 14'h0, {11'h0, h1oe});
        cmp("oe2", 14'h0, {10'h0, h2oe});
        $display("test headers and defaults done");
        link_run = 1'b0;
        acc = 0;
        for (k = 1; k < 13; k++)
        begin
            if (rdy === 1'b1)
            begin
                acc++;
                last = k;
            end
            wr = 1'b1;
            wdata = 14'(k);
            tick;
        end
        wr = 1'b0;
        cmp("ready", 14'h0, {13'h0, rdy});
        cmp("accepted", 14'h1, {13'h0, acc >= 8 && acc <= 9});
        link_run = 1'b1;
        settle;
        cmp("active", 14'(last), act);
        $display("test queue full done");
        end_of_test;
    end
endmodule
`default_nettype wire
